// [discrete_io_pkg.sv]
// shared constants, field layouts and state types of the two-axis discrete port
package discrete_io_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_MHZ       = 100;
	localparam int INIT_TIME_NS  = 1000;
	localparam int INIT_CYCLES   = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int INIT_W        = 8;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_MODE_TYPE  = 8'h00;
	localparam logic [7:0] OFS_CODING     = 8'h04;
	localparam logic [7:0] OFS_AXIS1_BITS = 8'h08;
	localparam logic [7:0] OFS_STATUS     = 8'h0C;
	localparam logic [7:0] OFS_AXIS1_POS  = 8'h10;
	localparam logic [7:0] OFS_AXIS2_POS  = 8'h14;

	// register reset values
	localparam logic [7:0] RST_MODE_TYPE  = 8'h03;
	localparam logic [7:0] RST_CODING     = 8'h00;
	localparam logic [7:0] RST_AXIS1_BITS = 8'h07;

	// configuration encodings
	localparam logic [7:0] MODE_INDEPENDENT = 8'h03;
	localparam logic [7:0] CODING_BINARY    = 8'h00;
	localparam logic [3:0] BIN_BITS_MIN     = 4'h1;
	localparam logic [3:0] BIN_BITS_MAX     = 4'hC;
	localparam logic [3:0] BCD_DIGIT_BITS   = 4'h4;
	localparam logic [3:0] BCD_TWO_BITS     = 4'h8;
	localparam logic [7:0] BCD_TWO_DIGITS   = 8'h02;

	// status register bit positions
	localparam int ST_READY    = 0;
	localparam int ST_FAULT_N  = 1;
	localparam int ST_IN_POS   = 2;
	localparam int ST_HOMED    = 4;
	localparam int ST_SERVO    = 6;
	localparam int ST_HOME_ERR = 8;
	localparam int ST_EXT_ERR  = 9;
	localparam int ST_FATAL    = 10;

	// ==========================================================
	// layout of the synchronised input vector
	localparam int PIN_START   = 0;
	localparam int PIN_HOME    = 1;
	localparam int PIN_SERVO   = 2;
	localparam int PIN_HOLD_N  = 3;
	localparam int PIN_ABORT_N = 4;
	localparam int PINS_AXIS   = 5;
	localparam int PIN_CLEAR   = 10;
	localparam int PIN_POS     = 11;
	localparam int POS_BITS    = 13;
	localparam int NUM_W       = 12;
	localparam int SYNC_W      = 24;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       start;
		logic       home;
		logic       servo_en;
		logic       hold_n;
		logic       abort_n;
	} axis_pins_t;

	typedef struct packed {
		logic [1:0] move_start;
		logic [1:0] homing_start;
		logic [1:0] servo_on;
		logic [1:0] decel_stop;
		logic [1:0] abort;
	} motion_cmd_t;

	typedef struct packed {
		logic [7:0]              mode_type;
		logic [7:0]              coding;
		logic [7:0]              axis1_bits;
		logic [1:0]              in_pos;
		logic [1:0]              homed;
		logic [1:0]              homing;
		logic [1:0]              moving;
		motion_cmd_t             cmd;
		logic [1:0][NUM_W-1:0]   target;
		logic                    home_err;
		logic                    ext_err;
		logic                    fatal;
		logic                    fault_n;
		logic                    ready;
		logic [INIT_W-1:0]       init_cnt;
		logic                    rd_pend;
		logic                    wr_pend;
		logic [7:0]              addr;
		logic                    hready;
		logic [31:0]             hrdata;
	} core_state_t;

endpackage

// [dual_axis_discrete_io_port.sv]
// two-axis discrete handshake port with position split and AHB-Lite registers
//
// Behaviour
// RULE_01 - axis-two start edge begins a move
// RULE_02 - axis-two homing edge begins homing
// RULE_03 - axis-two servo follows its enable input
// RULE_04 - hold low decelerates, high permits motion
// RULE_05 - abort falling discards remaining travel
// RULE_06 - fault output high normally, low on alarm
// RULE_07 - ready rises after initialisation completes
// RULE_08 - in-position once target reached inside band
// RULE_09 - homed cleared at reset, set on completion
// RULE_10 - servo status mirrors energised servo
// RULE_11 - mode type three selects independent operation
// RULE_12 - coding zero binary, nonzero BCD, default zero
// RULE_13 - axis-one share: bits 1-12 or digits
// RULE_14 - low bits to axis one, rest axis two
// RULE_15 - binary group, lowest input is LSB
// RULE_16 - BCD digits four bits, units first
// RULE_17 - BCD share only in whole nibbles
// RULE_18 - two-digit axis one leaves one digit
// RULE_19 - commands ignored silently while servo off
// RULE_20 - start before homing raises homing error
// RULE_21 - in-position drops on start, waits release
// RULE_22 - error clear edge clears resettable alarms
// RULE_23 - position sampled on the start edge cycle
// RULE_24 - inputs synchronised before edge detection
`timescale 1ns/10ps
`default_nettype none

module dual_axis_discrete_io_port
	import discrete_io_pkg::*;
(
	input  wire logic                  ref_clk_in,
	input  wire logic                  nrst_in,
	// handshake pins from the host controller
	input  wire logic                  first_axis_start_in,
	input  wire logic                  first_axis_homing_req_in,
	input  wire logic                  first_axis_servo_enable_in,
	input  wire logic                  first_axis_hold_n_in,
	input  wire logic                  first_axis_abort_n_in,
	input  wire logic                  second_axis_start_in,
	input  wire logic                  second_axis_homing_req_in,
	input  wire logic                  second_axis_servo_enable_in,
	input  wire logic                  second_axis_hold_n_in,
	input  wire logic                  second_axis_abort_n_in,
	input  wire logic [POS_BITS-1:0]   position_bits_in,
	input  wire logic                  error_clear_in,
	// handshake pins to the host controller
	output logic                       fault_n_out,
	output logic                       ready_out,
	output logic                       first_axis_in_position_out,
	output logic                       second_axis_in_position_out,
	output logic                       first_axis_homed_out,
	output logic                       second_axis_homed_out,
	output logic                       first_axis_servo_status_out,
	output logic                       second_axis_servo_status_out,
	// motion core side, same clock
	input  wire logic [1:0]            axis_reached_in,
	input  wire logic [1:0]            homing_done_in,
	input  wire logic                  alarm_in,
	input  wire logic                  fatal_alarm_in,
	output motion_cmd_t                motion_cmd_out,
	output logic [1:0][NUM_W-1:0]      axis_target_out,
	// AHB-Lite slave
	input  wire logic                  hsel_in,
	input  wire logic [31:0]           haddr_in,
	input  wire logic [1:0]            htrans_in,
	input  wire logic                  hwrite_in,
	input  wire logic [2:0]            hsize_in,
	input  wire logic [31:0]           hwdata_in,
	input  wire logic                  hready_in,
	output logic [31:0]                hrdata_out,
	output logic                       hreadyout_out,
	output logic                       hresp_out
);

	// ==========================================================
	// position decode helpers

	// width in bits of the axis-one share
	function automatic logic [3:0] axis1_share(input logic [7:0] coding, input logic [7:0] bits);
		logic [3:0] share;
		share = BIN_BITS_MIN;
		if (coding == CODING_BINARY) begin
			if (bits > 8'(BIN_BITS_MAX)) begin
				share = BIN_BITS_MAX;                          // [RULE_13]
			end else if (bits >= 8'(BIN_BITS_MIN)) begin
				share = bits[3:0];                             // [RULE_13]
			end
		end else if (bits == BCD_TWO_DIGITS || bits >= 8'(BCD_TWO_BITS)) begin
			share = BCD_TWO_BITS;                              // [RULE_17]
		end else begin
			share = BCD_DIGIT_BITS;                            // [RULE_17]
		end
		return share;
	endfunction

	// two BCD digits to binary, tens optional
	function automatic logic [NUM_W-1:0] bcd_value(input logic [7:0] digits, input logic use_tens);
		logic [NUM_W-1:0] units;
		logic [NUM_W-1:0] tens;
		units = NUM_W'(digits[3:0]);                           // [RULE_16]
		tens  = NUM_W'(digits[7:4]);
		return use_tens ? NUM_W'(units + tens * NUM_W'(10)) : units;
	endfunction

	// position number of one axis from the shared field
	function automatic logic [NUM_W-1:0] decode_pos(input logic [POS_BITS-1:0] pos,
		input logic [7:0] coding, input logic [7:0] bits, input logic axis2);
		logic [3:0]          share;
		logic [POS_BITS-1:0] low;
		logic [POS_BITS-1:0] high;
		logic                two_digit;
		share     = axis1_share(coding, bits);
		low       = pos & ((POS_BITS'(1) << share) - POS_BITS'(1));   // [RULE_14]
		high      = pos >> share;                                      // [RULE_14]
		two_digit = (share == BCD_TWO_BITS);
		if (coding == CODING_BINARY) begin
			return axis2 ? high[NUM_W-1:0] : low[NUM_W-1:0];            // [RULE_15]
		end else if (!axis2) begin
			return bcd_value(low[7:0], two_digit);                      // [RULE_16]
		end else begin
			return bcd_value(high[7:0], !two_digit);                    // [RULE_18]
		end
	endfunction

	// ==========================================================
	// input synchronisers
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_lvl;
	logic [SYNC_W-1:0] pins_rise;
	axis_pins_t        axis0_pins;
	axis_pins_t        axis1_pins;

	assign axis0_pins = '{first_axis_start_in, first_axis_homing_req_in, first_axis_servo_enable_in,
		first_axis_hold_n_in, first_axis_abort_n_in};
	assign axis1_pins = '{second_axis_start_in, second_axis_homing_req_in, second_axis_servo_enable_in,
		second_axis_hold_n_in, second_axis_abort_n_in};
	// start at bit 0 of each group, abort at bit 4
	// hold and abort enter inverted: idle matches the cleared chain, so no stop after reset
	assign pins_raw = {position_bits_in, error_clear_in,
		~axis1_pins.abort_n, ~axis1_pins.hold_n, axis1_pins.servo_en, axis1_pins.home, axis1_pins.start,
		~axis0_pins.abort_n, ~axis0_pins.hold_n, axis0_pins.servo_en, axis0_pins.home, axis0_pins.start};

	input_sync #(
		.W          (SYNC_W)
	) u_sync (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.din_in     (pins_raw),
		.level_out  (pins_lvl),
		.rise_out   (pins_rise),
		.fall_out   ()
	);

	logic [POS_BITS-1:0] pos_now;
	assign pos_now = pins_lvl[PIN_POS +: POS_BITS];

	// ==========================================================
	// state
	core_state_t state_reg;
	core_state_t state_next;
	logic        bus_take;
	logic        err_clear;
	logic [31:0] status_word;
	logic [1:0]  servo_lvl;
	logic [1:0]  hold_lvl_n;
	logic [1:0]  start_lvl;

	assign bus_take = hsel_in & htrans_in[1] & hready_in;

	// ==========================================================
	// handshake, alarms and bus
	always_comb begin
		state_next = state_reg;
		err_clear  = pins_rise[PIN_CLEAR];
		for (int a = 0; a < 2; a++) begin
			servo_lvl[a]  = pins_lvl[a*PINS_AXIS + PIN_SERVO];
			hold_lvl_n[a] = !pins_lvl[a*PINS_AXIS + PIN_HOLD_N];
			start_lvl[a]  = pins_lvl[a*PINS_AXIS + PIN_START];
		end

		// initialisation count, then ready in independent mode
		if (state_reg.init_cnt != INIT_W'(INIT_CYCLES)) begin
			state_next.init_cnt = state_reg.init_cnt + INIT_W'(1);
		end
		state_next.ready = (state_reg.init_cnt == INIT_W'(INIT_CYCLES))       // [RULE_07]
			&& (state_reg.mode_type == MODE_INDEPENDENT) && !state_reg.fatal;  // [RULE_11]

		// alarms: clear first so a same-cycle event wins
		if (err_clear) begin
			state_next.home_err = 1'b0;                        // [RULE_22]
			state_next.ext_err  = 1'b0;                        // [RULE_22]
		end
		if (alarm_in) begin
			state_next.ext_err = 1'b1;
		end
		if (fatal_alarm_in) begin
			state_next.fatal = 1'b1;
		end

		// per-axis command handling
		for (int a = 0; a < 2; a++) begin
			state_next.cmd.move_start[a]   = 1'b0;
			state_next.cmd.homing_start[a] = 1'b0;
			state_next.cmd.abort[a]        = 1'b0;
			if (state_reg.ready && pins_rise[a*PINS_AXIS + PIN_START] && servo_lvl[a]) begin  // [RULE_19]
				state_next.in_pos[a] = 1'b0;                           // [RULE_21]
				if (!state_reg.homed[a]) begin
					state_next.home_err = 1'b1;                        // [RULE_20]
				end else begin
					state_next.cmd.move_start[a] = 1'b1;               // [RULE_01]
					state_next.moving[a]         = 1'b1;
					state_next.target[a]         = decode_pos(pos_now, state_reg.coding,
						state_reg.axis1_bits, a[0]);                   // [RULE_23]
				end
			end
			if (state_reg.ready && pins_rise[a*PINS_AXIS + PIN_HOME] && servo_lvl[a]) begin   // [RULE_19]
				state_next.cmd.homing_start[a] = 1'b1;                 // [RULE_02]
				state_next.homing[a]           = 1'b1;
				state_next.homed[a]            = 1'b0;
				state_next.in_pos[a]           = 1'b0;
			end
			if (state_reg.homing[a] && homing_done_in[a]) begin
				state_next.homing[a] = 1'b0;
				state_next.homed[a]  = 1'b1;                           // [RULE_09]
			end
			if (pins_rise[a*PINS_AXIS + PIN_ABORT_N]) begin
				state_next.cmd.abort[a] = 1'b1;                        // [RULE_05]
				state_next.moving[a]    = 1'b0;                        // [RULE_05]
			end
			state_next.cmd.decel_stop[a] = !hold_lvl_n[a];             // [RULE_04]
			// completion only with start released, hold off and servo on
			if (state_reg.ready && axis_reached_in[a] && !start_lvl[a] && hold_lvl_n[a]
				&& state_reg.cmd.servo_on[a] && !state_reg.homing[a] && !state_next.cmd.move_start[a]) begin
				state_next.in_pos[a] = 1'b1;                           // [RULE_08] [RULE_21]
				state_next.moving[a] = 1'b0;
			end
			// servo stays on until a running move or homing ends
			state_next.cmd.servo_on[a] = servo_lvl[a] | state_reg.moving[a] | state_reg.homing[a];  // [RULE_03] [RULE_10]
		end

		state_next.fault_n = !(state_next.home_err | state_next.ext_err | state_next.fatal);  // [RULE_06]

		// bus: writes land in the data phase, reads take one wait state
		state_next.wr_pend = 1'b0;
		state_next.rd_pend = 1'b0;
		state_next.hready  = 1'b1;
		if (state_reg.wr_pend) begin
			case (state_reg.addr)
				OFS_MODE_TYPE:  state_next.mode_type  = hwdata_in[7:0];   // [RULE_11]
				OFS_CODING:     state_next.coding     = hwdata_in[7:0];   // [RULE_12]
				OFS_AXIS1_BITS: state_next.axis1_bits = hwdata_in[7:0];   // [RULE_13]
				default:        state_next.addr       = state_reg.addr;
			endcase
		end
		if (state_reg.rd_pend) begin
			case (state_reg.addr)
				OFS_MODE_TYPE:  state_next.hrdata = {24'h000000, state_reg.mode_type};
				OFS_CODING:     state_next.hrdata = {24'h000000, state_reg.coding};
				OFS_AXIS1_BITS: state_next.hrdata = {24'h000000, state_reg.axis1_bits};
				OFS_STATUS:     state_next.hrdata = status_word;
				OFS_AXIS1_POS:  state_next.hrdata = {20'h00000, state_reg.target[0]};
				OFS_AXIS2_POS:  state_next.hrdata = {20'h00000, state_reg.target[1]};
				default:        state_next.hrdata = 32'h00000000;
			endcase
		end else if (bus_take) begin
			state_next.addr    = haddr_in[7:0];
			state_next.wr_pend = hwrite_in;
			state_next.rd_pend = !hwrite_in;
			state_next.hready  = hwrite_in;
		end
	end

	// status word from live state
	always_comb begin
		status_word                    = 32'h00000000;
		status_word[ST_READY]          = state_reg.ready;
		status_word[ST_FAULT_N]        = state_reg.fault_n;
		status_word[ST_IN_POS +: 2]    = state_reg.in_pos;
		status_word[ST_HOMED +: 2]     = state_reg.homed;
		status_word[ST_SERVO +: 2]     = state_reg.cmd.servo_on;
		status_word[ST_HOME_ERR]       = state_reg.home_err;
		status_word[ST_EXT_ERR]        = state_reg.ext_err;
		status_word[ST_FATAL]          = state_reg.fatal;
	end

	// state register
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			state_reg            <= '0;
			state_reg.mode_type  <= RST_MODE_TYPE;
			state_reg.coding     <= RST_CODING;                // [RULE_12]
			state_reg.axis1_bits <= RST_AXIS1_BITS;
			state_reg.fault_n    <= 1'b1;
			state_reg.hready     <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// outputs, all but hresp straight from the state register
	assign fault_n_out                  = state_reg.fault_n;     // [RULE_06]
	assign ready_out                    = state_reg.ready;
	assign first_axis_in_position_out   = state_reg.in_pos[0];
	assign second_axis_in_position_out  = state_reg.in_pos[1];
	assign first_axis_homed_out         = state_reg.homed[0];
	assign second_axis_homed_out        = state_reg.homed[1];
	assign first_axis_servo_status_out  = state_reg.cmd.servo_on[0];
	assign second_axis_servo_status_out = state_reg.cmd.servo_on[1];
	assign motion_cmd_out               = state_reg.cmd;
	assign axis_target_out              = state_reg.target;
	assign hrdata_out                   = state_reg.hrdata;
	assign hreadyout_out                = state_reg.hready;
	assign hresp_out                    = 1'b0;                  // always OKAY

endmodule
`default_nettype wire

// [dual_axis_port_monitor.sv]
// concurrent checks on the pins of the two-axis discrete port
`timescale 1ns/10ps
`default_nettype none

module dual_axis_port_monitor
	import discrete_io_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        second_axis_hold_n_in,
	input  wire logic        second_axis_abort_n_in,
	input  wire logic        second_axis_servo_enable_in,
	input  wire logic [1:0]  axis_reached_in,
	input  wire logic        fatal_alarm_in,
	input  wire logic        fault_n_out,
	input  wire logic        ready_out,
	input  wire logic        second_axis_homed_out,
	input  wire logic        second_axis_in_position_out,
	input  wire logic        second_axis_servo_status_out,
	input  wire motion_cmd_t motion_cmd_out
);
	// ==========
	// pin relations, one clock domain
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	chk_move_needs_home: assert property (motion_cmd_out.move_start[1] |-> second_axis_homed_out)
		else $error("move issued before homing");
	chk_move_one_pulse: assert property (motion_cmd_out.move_start[1] |=> !motion_cmd_out.move_start[1])
		else $error("start edge gave more than one move");
	chk_move_drops_pos: assert property (motion_cmd_out.move_start[1] |-> !second_axis_in_position_out)
		else $error("in-position kept on move");
	chk_servo_status: assert property ($rose(second_axis_servo_status_out)
		|-> $past(second_axis_servo_enable_in, 4)) else $error("servo status rose without enable");
	chk_home_needs_servo: assert property (motion_cmd_out.homing_start[1] |-> motion_cmd_out.servo_on[1])
		else $error("homing with servo off");
	chk_hold_decel: assert property (!second_axis_hold_n_in [*6] |-> motion_cmd_out.decel_stop[1])
		else $error("hold low without stop");
	chk_abort_pulse: assert property ($fell(second_axis_abort_n_in) |-> ##[2:8] motion_cmd_out.abort[1])
		else $error("abort not passed on");
	chk_fatal_fault: assert property (fatal_alarm_in |-> ##[1:4] !fault_n_out)
		else $error("fault output stayed high");
	chk_pos_after_reach: assert property ($rose(second_axis_in_position_out) |-> $past(axis_reached_in[1]))
		else $error("in-position without reach");
	chk_ready_waits: assert property ($rose(nrst_in) |-> !ready_out [*8])
		else $error("ready too early");
	chk_homed_cleared: assert property ($rose(nrst_in) |-> !second_axis_homed_out)
		else $error("homed set after reset");
endmodule

bind dual_axis_discrete_io_port dual_axis_port_monitor u_mon (.ref_clk_in, .nrst_in, .second_axis_hold_n_in,
	.second_axis_abort_n_in, .second_axis_servo_enable_in, .axis_reached_in, .fatal_alarm_in, .fault_n_out,
	.ready_out, .second_axis_homed_out, .second_axis_in_position_out, .second_axis_servo_status_out, .motion_cmd_out);
`default_nettype wire

// [host_plc_model.sv]
// host controller model driving the discrete handshake pins
`timescale 1ns/10ps
`default_nettype none

module host_plc_model
	import discrete_io_pkg::*;
(
	input  wire logic            ref_clk_in,
	input  wire logic [1:0]      in_pos_in,
	output var axis_pins_t [1:0] ax_out,
	output var logic [12:0]      pos_out,
	output var logic             clear_out
);
	// ==========
	// idle levels, hold and abort released high
	initial begin
		ax_out = {2{5'h03}};
		pos_out = 13'h0000;
		clear_out = 1'b0;
	end

	// level change right after an edge
	task automatic lev(input int a, input int f, input logic v);
		@(posedge ref_clk_in);
		ax_out[a][4-f] <= v;
	endtask

	// pin away from idle long enough to be seen once
	task automatic hit(input int a, input int f);
		lev(a, f, ~ax_out[a][4-f]);
		repeat (6) @(posedge ref_clk_in);
		ax_out[a][4-f] <= ~ax_out[a][4-f];
	endtask

	// position set first, start held until in-position drops
	task automatic start(input int a, input logic [12:0] p);
		int n;
		pos_out <= p;
		repeat (3) @(posedge ref_clk_in);
		lev(a, PIN_START, 1'b1);
		repeat (8) @(posedge ref_clk_in);
		for (n = 0; in_pos_in[a] !== 1'b0 && n < 50; n++)
			@(posedge ref_clk_in);
		ax_out[a][4] <= 1'b0;
		repeat (6) @(posedge ref_clk_in);
	endtask

	// error clear pulse
	task automatic clr();
		@(posedge ref_clk_in);
		clear_out <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		clear_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [input_sync.sv]
// three-stage synchroniser with agreed level and one-cycle edge pulses
`timescale 1ns/10ps
`default_nettype none

module input_sync
	import discrete_io_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         ref_clk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] din_in,
	output logic      [W-1:0] level_out,
	output logic      [W-1:0] rise_out,
	output logic      [W-1:0] fall_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
		logic [W-1:0] fall;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;
	logic [W-1:0] agree;

	// ==========================================================
	// shift chain; level moves only when stages two and three agree
	always_comb begin
		state_next    = state_reg;
		state_next.s1 = din_in;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		agree          = ~(state_reg.s2 ^ state_reg.s3);
		state_next.lvl = (agree & state_reg.s3) | (~agree & state_reg.lvl);   // [RULE_24]
		state_next.rise = state_next.lvl & ~state_reg.lvl;                     // [RULE_24]
		state_next.fall = ~state_next.lvl & state_reg.lvl;
	end

	// state register
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign level_out = state_reg.lvl;
	assign rise_out  = state_reg.rise;
	assign fall_out  = state_reg.fall;

endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the two-axis discrete port
`timescale 1ns/10ps
`default_nettype none

module tb
	import discrete_io_pkg::*;
;
	logic ref_clk_in = 0, nrst_in = 0, alarm_in = 0, fatal_alarm_in = 0, hsel_in = 0, hwrite_in = 0;
	logic [1:0] axis_reached_in = 2'h0, homing_done_in = 2'h0, htrans_in = 2'h0;
	logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd;
	logic fault_n_out, ready_out, hreadyout_out, hresp_out, clear;
	logic [1:0] inp, hmd, sv;
	logic [12:0] pos;
	logic [NUM_W-1:0] tg [2];
	axis_pins_t [1:0] ax;
	motion_cmd_t motion_cmd_out;
	logic [1:0][NUM_W-1:0] axis_target_out;
	logic [7:0] ra [4] = '{OFS_MODE_TYPE, OFS_CODING, OFS_AXIS1_BITS, 8'h20};
	int rv [4] = '{RST_MODE_TYPE, RST_CODING, RST_AXIS1_BITS, 0};
	int cc [7] = '{0, 0, 0, 1, 1, 1, 5};
	int cb [7] = '{7, 1, 12, 1, 2, 8, 8};
	int bad_count, checks, mv [2], hs [2], ab [2], p, e;

	always #5 ref_clk_in = ~ref_clk_in;

	dual_axis_discrete_io_port u_dut (.ref_clk_in, .nrst_in,
		.first_axis_start_in(ax[0].start), .first_axis_homing_req_in(ax[0].home),
		.first_axis_servo_enable_in(ax[0].servo_en), .first_axis_hold_n_in(ax[0].hold_n),
		.first_axis_abort_n_in(ax[0].abort_n), .second_axis_start_in(ax[1].start),
		.second_axis_homing_req_in(ax[1].home), .second_axis_servo_enable_in(ax[1].servo_en),
		.second_axis_hold_n_in(ax[1].hold_n), .second_axis_abort_n_in(ax[1].abort_n),
		.position_bits_in(pos), .error_clear_in(clear), .fault_n_out, .ready_out,
		.first_axis_in_position_out(inp[0]), .second_axis_in_position_out(inp[1]),
		.first_axis_homed_out(hmd[0]), .second_axis_homed_out(hmd[1]),
		.first_axis_servo_status_out(sv[0]), .second_axis_servo_status_out(sv[1]),
		.axis_reached_in, .homing_done_in, .alarm_in, .fatal_alarm_in, .motion_cmd_out,
		.axis_target_out, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2),
		.hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out);

	host_plc_model u_plc (.ref_clk_in, .in_pos_in(inp), .ax_out(ax), .pos_out(pos), .clear_out(clear));

	// ==========
	// reference model and helpers
	always @(posedge ref_clk_in)
		for (int a = 0; a < 2; a++) begin
			if (motion_cmd_out.move_start[a] === 1'b1) begin
				mv[a]++;
				tg[a] = axis_target_out[a];
			end
			if (motion_cmd_out.homing_start[a] === 1'b1)
				hs[a]++;
			if (motion_cmd_out.abort[a] === 1'b1)
				ab[a]++;
		end

	function automatic int dec(int cod, int bits, int v, int a);
		int sh;
		sh = cod == 0 ? (bits > 12 ? 12 : (bits < 1 ? 1 : bits)) : ((bits == 2 || bits >= 8) ? 8 : 4);
		v = a ? v >> sh : v & ((1 << sh) - 1);
		if (cod != 0)
			v = (v & 15) + ((a && sh == 8) ? 0 : 10 * ((v >> 4) & 15));
		return v;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask

	task automatic cmp(input string nm, input int exp, input logic [31:0] got);
		checks++;
		if (got !== 32'(exp)) begin
			bad_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic hwait();
		for (int n = 0; n < 50 && (n == 0 || hreadyout_out !== 1'b1); n++)
			@(posedge ref_clk_in);
		cmp("hready", 1, hreadyout_out);
	endtask

	// single word transfer, read data left in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_in <= 1'b1;
		htrans_in <= 2'h2;
		hwrite_in <= w;
		haddr_in <= {24'h0, a};
		hwait();
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		hwait();
		rd = hrdata_out;
		cmp("hresp", 0, hresp_out);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========
	// tests
	initial begin
		void'($urandom(60));
		cyc(4);
		nrst_in <= 1'b1;
		cyc(2);
		cmp("ready", 0, ready_out);
		cmp("homed", 0, hmd);
		cmp("fault_n", 1, fault_n_out);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0);
			cmp("reg", rv[i], rd);
		end
		for (e = 0; ready_out !== 1'b1 && e < 300; e++)
			cyc(1);
		cmp("ready", 1, ready_out);
		$display("test reset done");
		u_plc.hit(1, PIN_START);
		cyc(8);
		cmp("move off", 0, mv[1]);
		bus(1'b0, OFS_STATUS, 32'h0);
		cmp("err off", 0, rd[ST_HOME_ERR]);
		u_plc.lev(0, PIN_SERVO, 1'b1);
		u_plc.lev(1, PIN_SERVO, 1'b1);
		cyc(8);
		cmp("servo", 3, sv);
		u_plc.hit(1, PIN_START);
		cyc(8);
		cmp("move unhomed", 0, mv[1]);
		cmp("fault_n", 0, fault_n_out);
		u_plc.clr();
		cyc(8);
		cmp("fault_n", 1, fault_n_out);
		alarm_in <= 1'b1;
		cyc(1);
		alarm_in <= 1'b0;
		cyc(4);
		cmp("fault_n", 0, fault_n_out);
		u_plc.clr();
		cyc(8);
		cmp("fault_n", 1, fault_n_out);
		$display("test servo and alarm done");
		for (int a = 0; a < 2; a++) begin
			u_plc.hit(a, PIN_HOME);
			cyc(4);
			cmp("homing", 1, hs[a]);
			homing_done_in[a] <= 1'b1;
			cyc(1);
			homing_done_in[a] <= 1'b0;
			cyc(3);
			cmp("homed", 1, hmd[a]);
		end
		$display("test homing done");
		foreach (cc[i]) begin
			bus(1'b1, OFS_CODING, 32'(cc[i]));
			bus(1'b1, OFS_AXIS1_BITS, 32'(cb[i]));
			for (int a = 0; a < 2; a++) begin
				p = $urandom & (cc[i] != 0 ? 32'h0777 : 32'h1FFF);
				e = mv[a];
				u_plc.start(a, 13'(p));
				cmp("moves", e + 1, mv[a]);
				cmp("target", dec(cc[i], cb[i], p, a), tg[a]);
				bus(1'b0, OFS_AXIS1_POS + 8'(4 * a), 32'h0);
				cmp("target reg", dec(cc[i], cb[i], p, a), rd);
				axis_reached_in[a] <= 1'b1;
				cyc(3);
				cmp("in_pos", 1, inp[a]);
				axis_reached_in[a] <= 1'b0;
			end
		end
		$display("test moves done");
		u_plc.lev(1, PIN_HOLD_N, 1'b0);
		cyc(10);
		cmp("decel", 1, motion_cmd_out.decel_stop[1]);
		u_plc.lev(1, PIN_HOLD_N, 1'b1);
		u_plc.hit(1, PIN_ABORT_N);
		cyc(4);
		cmp("abort", 1, ab[1]);
		bus(1'b1, OFS_MODE_TYPE, 32'h0);
		cyc(2);
		cmp("ready", 0, ready_out);
		fatal_alarm_in <= 1'b1;
		cyc(4);
		cmp("fault_n", 0, fault_n_out);
		u_plc.clr();
		cyc(8);
		cmp("fault_n", 0, fault_n_out);
		$display("test hold and fatal done");
		conclude();
	end

	// hang guard
	initial begin
		cyc(6000);
		bad_count++;
		$display("[ERR] watchdog expected end seen hang");
		conclude();
	end
endmodule
`default_nettype wire
